// ===== design/splf_ctrl.v
// Self-program, lock-bit and fuse-read controller with Wishbone slave
`timescale 1ns/1ps
`default_nettype none
`include "splf_defines.vh"

module splf_ctrl #(
	parameter TICK_CYCLES = `SPLF_TICK_CYCLES,
	parameter PROG_TICKS  = `SPLF_PROG_TICKS,
	parameter [15:0] BOOT_STALL_START = `SPLF_BOOT_STALL_START
) (
	// Clock and resets
	input  wire        CORE_CLK,
	input  wire        ARST_N,
	input  wire        SYS_RST_N,
	// Wishbone slave
	input  wire        WB_CYC,
	input  wire        WB_STB,
	input  wire        WB_WE,
	input  wire [7:0]  WB_ADR,
	input  wire [3:0]  WB_SEL,
	input  wire [31:0] WB_DAT_I,
	output reg  [31:0] WB_DAT_O,
	output reg         WB_ACK,
	// Core instruction side
	input  wire        SPM_EXEC,
	input  wire        LPM_EXEC,
	input  wire [15:0] Z_PTR,
	input  wire [7:0]  GR0_DATA,
	input  wire        EEPROM_WRITE_ACTIVE,
	// Fuse cells
	input  wire [7:0]  FUSE_LOW,
	input  wire [7:0]  FUSE_HIGH,
	input  wire [2:0]  FUSE_EXT,
	// Answers to the core
	output reg         LPM_ALT_VALID,
	output reg  [7:0]  LPM_ALT_DATA,
	output reg         CPU_HALT,
	output reg         APP_READ_BLOCK,
	output reg         IRQ,
	// Flash array control
	output reg         FL_ERASE,
	output reg         FL_WRITE,
	output reg  [15:0] FL_PAGE,
	output reg         FL_LOCK_WR,
	output reg  [5:0]  LOCK_BITS
);

	// ==========================================================
	// State encoding, one-hot
	localparam [2:0] ST_IDLE = 3'b001;
	localparam [2:0] ST_OPEN = 3'b010;
	localparam [2:0] ST_PROG = 3'b100;

	// ==========================================================
	// Declarations
	reg  [2:0]  st_q;          // Sequencer state
	reg  [4:0]  cmd_q;         // Command bits incl. store enable
	reg         irq_en_q;      // Interrupt enable bit
	reg         app_busy_q;    // App region busy flag
	reg  [2:0]  swin_q;        // Store window remaining
	reg  [2:0]  lwin_q;        // Load window remaining
	reg  [15:0] tick_div_q;    // Time base divider
	reg  [15:0] prog_cnt_q;    // Ticks left in an operation
	reg         op_lock_q;     // Operation is a lock write
	reg  [5:0]  lock_new_q;    // Lock value applied at the end

	wire        wb_req;        // New bus request this cycle
	wire        wb_wr;         // Write taking effect this cycle
	wire        wr_scr;        // Write to store control register
	wire [4:0]  wcmd;          // Written command bits
	wire        cmd_ok;        // Written code is accepted
	wire        tick;          // One-cycle time base pulse
	wire        store_hit;     // Store inside its window
	wire        load_hit;      // Load inside its window
	wire        prog_done;     // Operation end
	wire [7:0]  scr_rd;        // Store control readback
	wire        boot_tgt;      // Pointer in boot-stall region

	assign wb_req   = WB_CYC & WB_STB & ~WB_ACK;
	assign wb_wr    = wb_req & WB_WE & WB_SEL[0];
	assign wr_scr   = wb_wr & (WB_ADR == `SPLF_OFS_SCR);
	assign wcmd     = WB_DAT_I[4:0];
	// Unlisted codes and any code during an EEPROM write or a running operation start no command
	assign cmd_ok   = ((wcmd == `SPLF_CMD_REENABLE) |
	                   (wcmd == `SPLF_CMD_LOCK) |
	                   (wcmd == `SPLF_CMD_WRITE) |
	                   (wcmd == `SPLF_CMD_ERASE) |
	                   (wcmd == `SPLF_CMD_FILL)) &
	                  ~EEPROM_WRITE_ACTIVE &
	                  (st_q != ST_PROG);
	assign tick     = (tick_div_q == 16'h0000);
	// A held system reset or a late EEPROM write also refuses the
	// instruction, so strobes never start without the sequencer
	assign store_hit = SPM_EXEC & (st_q == ST_OPEN) & (swin_q != 3'h0) &
	                   SYS_RST_N & ~EEPROM_WRITE_ACTIVE;
	assign load_hit  = LPM_EXEC & (st_q == ST_OPEN) & (lwin_q != 3'h0) &
	                   (cmd_q == `SPLF_CMD_LOCK) & SYS_RST_N & ~EEPROM_WRITE_ACTIVE;
	assign prog_done = (st_q == ST_PROG) & tick & (prog_cnt_q == 16'h0001);
	assign scr_rd   = {irq_en_q, app_busy_q, 1'b0, cmd_q};
	assign boot_tgt = (Z_PTR >= BOOT_STALL_START);

	// ==========================================================
	// Wishbone slave: one wait-free answer cycle after each request
	// Unmapped offsets read zero and still acknowledge
	always @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			WB_ACK   <= 1'b0;
			WB_DAT_O <= 32'h0000_0000;
		end else begin
			WB_ACK <= wb_req;
			if (wb_req) begin
				case (WB_ADR)
					`SPLF_OFS_SCR: begin
						WB_DAT_O <= {24'h000000, scr_rd};
					end
					`SPLF_OFS_LOCK: begin
						// Programmed bits read as zero
						WB_DAT_O <= {24'h000000, 2'b11, LOCK_BITS};
					end
					`SPLF_OFS_STAT: begin
						WB_DAT_O <= {29'h00000000, EEPROM_WRITE_ACTIVE,
						             CPU_HALT, (st_q == ST_PROG)};
					end
					default: begin
						WB_DAT_O <= 32'h0000_0000;
					end
				endcase
			end
		end
	end

	// ==========================================================
	// Time base divider; restarted at each operation start so the
	// operation length is an exact multiple of the tick
	always @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			tick_div_q <= 16'h0000;
		end else if (store_hit && (cmd_q != `SPLF_CMD_FILL) &&
		             (cmd_q != `SPLF_CMD_REENABLE)) begin
			tick_div_q <= TICK_CYCLES[15:0] - 16'h0001;
		end else if (tick) begin
			tick_div_q <= TICK_CYCLES[15:0] - 16'h0001;
		end else begin
			tick_div_q <= tick_div_q - 16'h0001;
		end
	end

	// ==========================================================
	// Sequencer: command window, timed operation, self-clearing
	// The system reset clears an open window and keeps a new one from opening; a running
	// operation ignores it and finishes
	always @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			st_q       <= ST_IDLE;
			cmd_q      <= 5'h00;
			swin_q     <= 3'h0;
			lwin_q     <= 3'h0;
			prog_cnt_q <= 16'h0000;
			op_lock_q  <= 1'b0;
			lock_new_q <= `SPLF_LOCK_RST;
		end else begin
			case (st_q)
				ST_IDLE: begin
					// Accepted command opens both windows
					if (wr_scr && cmd_ok && SYS_RST_N) begin
						st_q   <= ST_OPEN;
						cmd_q  <= wcmd;
						swin_q <= `SPLF_STORE_WIN;
						lwin_q <= `SPLF_LOAD_WIN;
					end
				end
				ST_OPEN: begin
					if (!SYS_RST_N) begin
						st_q   <= ST_IDLE;
						cmd_q  <= 5'h00;
						swin_q <= 3'h0;
						lwin_q <= 3'h0;
					end else if (load_hit) begin
						// Fuse or lock read done, bits clear
						st_q   <= ST_IDLE;
						cmd_q  <= 5'h00;
						swin_q <= 3'h0;
						lwin_q <= 3'h0;
					end else if (store_hit) begin
						swin_q <= 3'h0;
						lwin_q <= 3'h0;
						case (cmd_q)
							`SPLF_CMD_ERASE, `SPLF_CMD_WRITE: begin
								st_q       <= ST_PROG;
								prog_cnt_q <= PROG_TICKS[15:0];
								op_lock_q  <= 1'b0;
							end
							`SPLF_CMD_LOCK: begin
								// Pointer not looked at here
								st_q       <= ST_PROG;
								prog_cnt_q <= PROG_TICKS[15:0];
								op_lock_q  <= 1'b1;
								// Only zeros program, ones never erase
								lock_new_q <= LOCK_BITS & GR0_DATA[5:0];
							end
							default: begin
								// Fill and re-enable end at once
								st_q  <= ST_IDLE;
								cmd_q <= 5'h00;
							end
						endcase
					end else if (wr_scr && cmd_ok) begin
						// Rewrite restarts the windows
						cmd_q  <= wcmd;
						swin_q <= `SPLF_STORE_WIN;
						lwin_q <= `SPLF_LOAD_WIN;
					end else begin
						if (swin_q != 3'h0) begin
							swin_q <= swin_q - 3'h1;
						end
						if (lwin_q != 3'h0) begin
							lwin_q <= lwin_q - 3'h1;
						end
						// Store window gone, bits clear
						if (swin_q == 3'h1) begin
							st_q  <= ST_IDLE;
							cmd_q <= 5'h00;
						end
					end
				end
				ST_PROG: begin
					// Store enable stays high until the end
					if (tick) begin
						prog_cnt_q <= prog_cnt_q - 16'h0001;
					end
					if (prog_done) begin
						st_q      <= ST_IDLE;
						cmd_q     <= 5'h00;
						op_lock_q <= 1'b0;
					end
				end
				default: begin
					st_q  <= ST_IDLE;
					cmd_q <= 5'h00;
				end
			endcase
		end
	end

	// ==========================================================
	// Interrupt enable and app region busy flag
	// Busy is set by hardware and only the re-enable command
	// clears it; a start in the same cycle wins
	always @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			irq_en_q   <= 1'b0;
			app_busy_q <= 1'b0;
		end else begin
			if (wr_scr) begin
				irq_en_q <= WB_DAT_I[`SPLF_B_IRQ_EN];
			end
			if (store_hit && ((cmd_q == `SPLF_CMD_ERASE) ||
			                  (cmd_q == `SPLF_CMD_WRITE))) begin
				app_busy_q <= 1'b1;
			end else if (store_hit && (cmd_q == `SPLF_CMD_REENABLE) &&
			             (st_q == ST_OPEN)) begin
				app_busy_q <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Flash array strobes, halt and read blocking
	always @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			FL_ERASE       <= 1'b0;
			FL_WRITE       <= 1'b0;
			FL_PAGE        <= 16'h0000;
			FL_LOCK_WR     <= 1'b0;
			CPU_HALT       <= 1'b0;
			APP_READ_BLOCK <= 1'b0;
		end else begin
			if (store_hit && (cmd_q == `SPLF_CMD_ERASE)) begin
				FL_ERASE <= 1'b1;
				FL_PAGE  <= Z_PTR;                             // Address latched
				CPU_HALT <= boot_tgt;
				APP_READ_BLOCK <= 1'b1;
			end else if (store_hit && (cmd_q == `SPLF_CMD_WRITE)) begin
				FL_WRITE <= 1'b1;
				FL_PAGE  <= Z_PTR;
				CPU_HALT <= boot_tgt;
				APP_READ_BLOCK <= 1'b1;
			end else if (store_hit && (cmd_q == `SPLF_CMD_LOCK)) begin
				// No blocking added: app region read blocking is left as it was
				FL_LOCK_WR <= 1'b1;
			end else if (prog_done) begin
				FL_ERASE   <= 1'b0;
				FL_WRITE   <= 1'b0;
				FL_LOCK_WR <= 1'b0;
				CPU_HALT   <= 1'b0;
			end
			// Blocking lasts as long as the busy flag
			if (store_hit && (cmd_q == `SPLF_CMD_REENABLE) &&
			    (st_q == ST_OPEN)) begin
				APP_READ_BLOCK <= 1'b0;
			end
		end
	end

	// ==========================================================
	// Lock bits; nonvolatile in silicon, reset value unprogrammed
	always @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			LOCK_BITS <= `SPLF_LOCK_RST;
		end else if (prog_done && op_lock_q) begin
			LOCK_BITS <= lock_new_q;
		end
	end

	// ==========================================================
	// Timed load answer: replaces the flash byte for one cycle.
	// Without the select window the core reads flash as usual.
	always @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			LPM_ALT_VALID <= 1'b0;
			LPM_ALT_DATA  <= 8'hff;
		end else begin
			LPM_ALT_VALID <= load_hit;
			if (load_hit) begin
				case (Z_PTR)
					`SPLF_Z_FUSE_LOW: begin
						LPM_ALT_DATA <= FUSE_LOW;
					end
					`SPLF_Z_FUSE_HIGH: begin
						LPM_ALT_DATA <= FUSE_HIGH;
					end
					`SPLF_Z_FUSE_EXT: begin
						// Upper bits undefined; driven high
						LPM_ALT_DATA <= {5'h1f, FUSE_EXT};
					end
					`SPLF_Z_LOCK: begin
						LPM_ALT_DATA <= {2'b11, LOCK_BITS};
					end
					default: begin
						LPM_ALT_DATA <= 8'hff;
					end
				endcase
			end
		end
	end

	// ==========================================================
	// Completion interrupt: a level, held while store enable is low
	always @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			IRQ <= 1'b0;
		end else begin
			IRQ <= irq_en_q & ~cmd_q[`SPLF_B_STORE_EN];
		end
	end

endmodule // splf_ctrl

`default_nettype wire

// ===== design/splf_defines.vh
// Constants for the self-program, lock and fuse controller
`ifndef SPLF_DEFINES_VH
`define SPLF_DEFINES_VH

// ==========================================================
// Register byte offsets on the Wishbone slave
`define SPLF_OFS_SCR        8'h00
`define SPLF_OFS_LOCK       8'h04
`define SPLF_OFS_STAT       8'h08

// ==========================================================
// Store control register fields
`define SPLF_B_STORE_EN     0
`define SPLF_B_ERASE        1
`define SPLF_B_WRITE        2
`define SPLF_B_LOCK_SEL     3
`define SPLF_B_REENABLE     4
`define SPLF_B_APP_BUSY     6
`define SPLF_B_IRQ_EN       7

// Accepted command codes in the low five bits
`define SPLF_CMD_REENABLE   5'h11
`define SPLF_CMD_LOCK       5'h09
`define SPLF_CMD_WRITE      5'h05
`define SPLF_CMD_ERASE      5'h03
`define SPLF_CMD_FILL       5'h01

// ==========================================================
// Pointer values selecting fuse and lock bytes
`define SPLF_Z_FUSE_LOW     16'h0000
`define SPLF_Z_LOCK         16'h0001
`define SPLF_Z_FUSE_EXT     16'h0002
`define SPLF_Z_FUSE_HIGH    16'h0003

// ==========================================================
// Reset values
`define SPLF_LOCK_RST       6'h3f
`define SPLF_SCR_RST        8'h00

// ==========================================================
// Timing
`define SPLF_CLK_PERIOD_NS  100
`define SPLF_T_TICK_NS      1000
`define SPLF_T_PROG_MIN_NS  3700000
`define SPLF_T_PROG_MAX_NS  4500000
`define SPLF_TICK_CYCLES    (`SPLF_T_TICK_NS / `SPLF_CLK_PERIOD_NS)
`define SPLF_PROG_TICKS     ((`SPLF_T_PROG_MIN_NS + `SPLF_T_TICK_NS - 1) / `SPLF_T_TICK_NS)
`define SPLF_STORE_WIN      3'h4
`define SPLF_LOAD_WIN       3'h3

// Start of the boot-stall region, byte address
`define SPLF_BOOT_STALL_START 16'h7000

`endif

// ===== verification/splf_chk.sv
// Port checker for the self-program, lock and fuse controller
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Checker
module splf_chk #(
	parameter TICK_CYCLES = 2,
	parameter PROG_TICKS  = 4
) (
	// Clock and reset
	input wire logic       CORE_CLK,
	input wire logic       ARST_N,
	// Bus and core side
	input wire logic       WB_CYC,
	input wire logic       WB_STB,
	input wire logic       WB_ACK,
	input wire logic       LPM_EXEC,
	input wire logic       EEPROM_WRITE_ACTIVE,
	// Answers and flash control
	input wire logic       LPM_ALT_VALID,
	input wire logic       CPU_HALT,
	input wire logic       APP_READ_BLOCK,
	input wire logic       IRQ,
	input wire logic       FL_ERASE,
	input wire logic       FL_WRITE,
	input wire logic       FL_LOCK_WR,
	input wire logic [5:0] LOCK_BITS
);
	localparam int OPN = PROG_TICKS * TICK_CYCLES;
	logic        fl_any;  // Any flash operation running
	logic [15:0] run_q;   // Cycles the current operation has run
	assign fl_any = FL_ERASE | FL_WRITE | FL_LOCK_WR;
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (!ARST_N);
	// Length counter; a counter keeps the long hold out of the solver
	always @(posedge CORE_CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			run_q <= 16'h0000;
		end else begin
			run_q <= fl_any ? run_q + 16'h0001 : 16'h0000;
		end
	end
	AST_WB_ACK: assert property (WB_CYC && WB_STB && !WB_ACK |=> WB_ACK ##1 !WB_ACK)
		else $error("bus answer not a single pulse one cycle after request");
	AST_IRQ_OFF: assert property (fl_any |-> !IRQ)
		else $error("interrupt raised while store enable still set");
	AST_OP_LEN: assert property ($fell(fl_any) |-> run_q == OPN)
		else $error("flash operation length wrong");
	AST_BLOCK: assert property (FL_ERASE || FL_WRITE |-> APP_READ_BLOCK)
		else $error("app region readable during erase or write");
	AST_HALT: assert property (CPU_HALT |-> FL_ERASE || FL_WRITE)
		else $error("core halted with no page operation");
	AST_LOCK_RD: assert property (FL_LOCK_WR && !$past(APP_READ_BLOCK) |-> !APP_READ_BLOCK && !CPU_HALT)
		else $error("flash not readable during lock programming");
	AST_EE_PROG: assert property (EEPROM_WRITE_ACTIVE [*6] |-> !$rose(fl_any))
		else $error("flash operation started during eeprom write");
	AST_EE_READ: assert property (EEPROM_WRITE_ACTIVE [*4] |=> !LPM_ALT_VALID)
		else $error("fuse or lock read during eeprom write");
	AST_LOAD_ANS: assert property (LPM_ALT_VALID |-> $past(LPM_EXEC))
		else $error("load answer without a load one cycle before");
	AST_ONE_SHOT: assert property (LPM_ALT_VALID |=> !LPM_ALT_VALID)
		else $error("load answer longer than one cycle");
	AST_LOCK_PROG: assert property ($changed(LOCK_BITS) |-> $past(FL_LOCK_WR) && (LOCK_BITS & ~$past(LOCK_BITS)) == 6'h00)
		else $error("lock bits changed outside lock write or unprogrammed");
endmodule // splf_chk
bind splf_ctrl splf_chk #(.TICK_CYCLES(TICK_CYCLES), .PROG_TICKS(PROG_TICKS)) u_chk (
	.CORE_CLK(CORE_CLK), .ARST_N(ARST_N), .WB_CYC(WB_CYC), .WB_STB(WB_STB), .WB_ACK(WB_ACK),
	.LPM_EXEC(LPM_EXEC), .EEPROM_WRITE_ACTIVE(EEPROM_WRITE_ACTIVE), .LPM_ALT_VALID(LPM_ALT_VALID),
	.CPU_HALT(CPU_HALT), .APP_READ_BLOCK(APP_READ_BLOCK), .IRQ(IRQ), .FL_ERASE(FL_ERASE),
	.FL_WRITE(FL_WRITE), .FL_LOCK_WR(FL_LOCK_WR), .LOCK_BITS(LOCK_BITS));
`default_nettype wire

// ===== verification/splf_core_mdl.sv
// Core model issuing timed store and load instructions
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Core model
module splf_core_mdl (
	// Clock
	input  wire logic       clk,
	// Requests from the bench
	input  wire logic       go,
	input  wire logic       ld,
	input  wire logic [2:0] dly,
	input  wire logic [5:0] lock_in,
	// Instruction side
	output var  logic       spm,
	output var  logic       lpm,
	output wire logic [7:0] gr0
);
	// Top two lock data bits always one for compatibility
	assign gr0 = {2'b11, lock_in};
	initial begin
		spm = 1'b0;
		lpm = 1'b0;
	end
	// Delay lets a test place the instruction inside or past the window
	always @(posedge clk) begin
		if (go) begin
			repeat (dly) @(posedge clk);
			if (ld) begin
				lpm <= 1'b1;
			end else begin
				spm <= 1'b1;
			end
			@(posedge clk);
			spm <= 1'b0;
			lpm <= 1'b0;
		end
	end
endmodule // splf_core_mdl
`default_nettype wire

// ===== verification/tb_top.sv
// Self-checking bench for the self-program controller
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	// ==========================================
	// Signals
	logic        clk, arst_n, srst_n, cyc, stb, we, ee, go, ld;
	logic [7:0]  adr, flo, fhi;
	logic [2:0]  fex, dly;
	logic [15:0] z;
	logic [5:0]  lkd;
	logic [31:0] wdat, seed, e, exq[$];
	wire logic   ack, spm, lpm, aval, halt, blk, irq, fer, fwr, flk;
	wire logic [31:0] rdat;
	wire logic [15:0] page;
	wire logic [7:0]  adat, gr0;
	wire logic [5:0]  lock;
	int          num_errors, check_count, i;
	// ==========================================
	// Design and core model
	splf_ctrl #(.TICK_CYCLES(2), .PROG_TICKS(4)) dut (.CORE_CLK(clk), .ARST_N(arst_n),
		.SYS_RST_N(srst_n), .WB_CYC(cyc), .WB_STB(stb), .WB_WE(we), .WB_ADR(adr), .WB_SEL(4'hf),
		.WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK(ack), .SPM_EXEC(spm), .LPM_EXEC(lpm), .Z_PTR(z),
		.GR0_DATA(gr0), .EEPROM_WRITE_ACTIVE(ee), .FUSE_LOW(flo), .FUSE_HIGH(fhi), .FUSE_EXT(fex),
		.LPM_ALT_VALID(aval), .LPM_ALT_DATA(adat), .CPU_HALT(halt), .APP_READ_BLOCK(blk), .IRQ(irq),
		.FL_ERASE(fer), .FL_WRITE(fwr), .FL_PAGE(page), .FL_LOCK_WR(flk), .LOCK_BITS(lock));
	splf_core_mdl u_core (.clk(clk), .go(go), .ld(ld), .dly(dly), .lock_in(lkd), .spm(spm),
		.lpm(lpm), .gr0(gr0));
	// ==========================================
	// Clock, helpers
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	function automatic logic [31:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		check_count++;
		if (seen !== exp) begin
			num_errors++;
			$display("[ERR] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task summarize;
		if (num_errors == 0 && check_count > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	// Classic cycle; held until ack is sampled, never assumes a latency
	task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; wdat <= d;
		do begin @(posedge clk); n++; end while (ack !== 1'b1 && n < 20);
		chk({31'h0, ack}, 32'h1);
		cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
	endtask
	task rd(input logic [7:0] a, input logic [31:0] x);
		exq.push_back(x);
		wb(1'b0, a, 32'h0);
	endtask
	// Command write then one instruction from the core after d extra cycles
	task cmd(input logic [7:0] c, input logic l, input logic [2:0] d);
		wb(1'b1, 8'h00, {24'h0, c});
		dly <= d; ld <= l; go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
	endtask
	task idle(input int n);
		repeat (n) @(posedge clk);
	endtask
	task wait_op;
		int n;
		n = 0;
		idle(3);
		while ((fer | fwr | flk) !== 1'b0 && n < 100) begin @(posedge clk); n++; end
		chk({31'h0, fer | fwr | flk}, 32'h0);
	endtask
	// ==========================================
	// Result watcher: oldest note against each answer
	always @(posedge clk) begin
		if ((ack && cyc && !we) || aval) begin
			if (exq.size() == 0) chk(32'h1, 32'h0);
			else chk(aval ? {24'h0, adat} : rdat, exq.pop_front());
		end
	end
	// Watchdog
	initial begin
		idle(20000);
		num_errors++;
		summarize;
	end
	// ==========================================
	// Main sequence
	initial begin
		seed = 32'hdc88f461; num_errors = 0; check_count = 0; arst_n = 1'b0; srst_n = 1'b1;
		cyc = 1'b0; stb = 1'b0; we = 1'b0; adr = 8'h00; wdat = 32'h0; ee = 1'b0; go = 1'b0;
		ld = 1'b0; dly = 3'h0; z = 16'h0000; lkd = 6'h3f;
		e = rnd(); flo = e[7:0]; fhi = e[15:8]; fex = e[18:16];
		idle(10);
		arst_n <= 1'b1;
		// Reset values, unmapped place reads zero
		rd(8'h00, 32'h0); rd(8'h04, 32'hff); rd(8'h08, 32'h0); rd(8'h0c, 32'h0);
		// Every fuse and lock byte through the timed load
		for (i = 0; i < 4; i++) begin
			z <= i[15:0];
			exq.push_back(i == 0 ? {24'h0, flo} : i == 1 ? 32'hff : i == 2 ? {29'h1f, fex} : {24'h0, fhi});
			cmd(8'h09, 1'b1, 3'h0);
			idle(4);
		end
		rd(8'h00, 32'h0);
		// Load one cycle too late gets no answer
		cmd(8'h09, 1'b1, 3'h1); idle(6); rd(8'h00, 32'h0);
		// App region erase with interrupt enabled
		z <= 16'h0100; cmd(8'h83, 1'b0, 3'h1); idle(3);
		chk({fer, blk, halt}, 32'h6);
		wait_op; idle(2);
		chk({31'h0, irq}, 32'h1);
		rd(8'h00, 32'hc0);
		cmd(8'h87, 1'b0, 3'h0); idle(3); rd(8'h00, 32'hc0);
		cmd(8'h91, 1'b0, 3'h0); idle(3); rd(8'h00, 32'h80);
		cmd(8'h81, 1'b0, 3'h0); idle(3); rd(8'h00, 32'h80);
		// Boot-stall page write halts the core
		z <= 16'h7000; cmd(8'h05, 1'b0, 3'h0); idle(2);
		chk({page, 14'h0, halt, fwr}, 32'h70000003);
		wait_op; cmd(8'h11, 1'b0, 3'h0); idle(3);
		// Lock write with a random pointer
		e = rnd(); lkd <= e[5:0] & 6'h3e; z <= e[31:16];
		cmd(8'h09, 1'b0, 3'h1); idle(3);
		chk({flk, blk, halt}, 32'h4);
		wait_op; rd(8'h04, {24'h0, 2'b11, e[5:0] & 6'h3e});
		// Store one cycle too late is dropped
		cmd(8'h03, 1'b0, 3'h2); idle(8); chk({31'h0, fer}, 32'h0);
		// Eeprom write refuses programming and fuse reads
		ee <= 1'b1;
		cmd(8'h03, 1'b0, 3'h0); idle(4); chk({31'h0, fer}, 32'h0);
		rd(8'h08, 32'h4); cmd(8'h09, 1'b1, 3'h0); idle(4); rd(8'h00, 32'h0);
		ee <= 1'b0;
		// System reset in mid erase does not stop it
		z <= 16'h0200; cmd(8'h03, 1'b0, 3'h0); idle(2); srst_n <= 1'b0; idle(2); srst_n <= 1'b1;
		chk({31'h0, fer}, 32'h1);
		wait_op; chk({31'h0, blk}, 32'h1);
		// Every noted answer must have arrived
		chk(exq.size(), 32'h0);
		summarize;
	end
endmodule // tb_top
`default_nettype wire
